/* include/tdc_pkg.sv */
// Package for the tape character data path and checking logic
package tdc_pkg;
    // Clock and character timing
    localparam int CLK_NS = 20;
    localparam int CHAR_TIME_US = 2000;
    localparam int CHAR_CYC = CHAR_TIME_US * 1000 / CLK_NS;
    localparam int TICKS_PER_CHAR = 10;
    localparam int TICK_CYC = CHAR_CYC / TICKS_PER_CHAR;
    localparam int SKEW_PCT = 45;
    localparam int SKEW_CYC = CHAR_CYC * SKEW_PCT / 100;
    localparam int RDCLK_DELAY_NS = 2000;
    localparam int RDCLK_DELAY_CYC = (RDCLK_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAW_TIME_NS = 1900000;
    localparam int RAW_CYC = RAW_TIME_NS / CLK_NS;
    localparam int CNT_W = 20;
    // Spacing in character-clock ticks and character spaces
    localparam logic [7:0] EXPECT_TICKS = 8'h0F;
    localparam logic [7:0] LOST_TICKS = 8'h11;
    localparam logic [7:0] GAP_TICKS = 8'h1E;
    localparam logic [7:0] TICK_SAT = 8'hFF;
    localparam logic [7:0] CHECK_SPACES = 8'h04;
    localparam logic [3:0] SPACE_LAST = 4'h9;
    // Load advance for write-only units
    localparam int BOT_MILS = 3500;
    localparam int STEP_MILS = 5;
    localparam logic [9:0] BOT_STEPS_M1 = 10'(BOT_MILS / STEP_MILS - 1);
    // Track layout
    localparam int TRK_W = 9;
    localparam int PAR7_BIT = 6;
    localparam logic [8:0] CRC_POLY_DEF = 9'h0B1;

    typedef struct packed {
        logic wr_sel;
        logic wr_step;
        logic wr_gap;
        logic [7:0] wr_data;
        logic ring_in;
        logic nine_track;
        logic binary_mode;
        logic load_cmd;
        logic load_point;
        logic rd_cmd;
        logic [TRK_W-1:0] rd_flux;
        logic [TRK_W-1:0] rb_flux;
    } tdc_pins_s;

    typedef struct packed {
        tdc_pins_s meta;
        tdc_pins_s q;
    } tdc_sync_s;

    typedef struct packed {
        logic [TRK_W-1:0] head_pol;
        logic head_pulse;
        logic erase_en;
        logic write_mode;
        logic protect_lamp;
        logic protect_status;
        logic raw_err;
        logic tape_step;
        logic gap_busy;
        logic load_busy;
    } tdc_wr_out_s;

    typedef struct packed {
        logic [TRK_W-1:0] data;
        logic rd_clk;
        logic gap_detect;
        logic par_err;
        logic lrc_err;
        logic lost_err;
    } tdc_rd_out_s;

    typedef struct packed {
        tdc_pins_s pv;
        logic [CNT_W-1:0] sub_div;
        logic tick;
        logic [3:0] sp_cnt;
        logic rd_busy;
        logic [CNT_W-1:0] skew_cnt;
        logic [TRK_W-1:0] acc;
        logic clk_wait;
        logic [CNT_W-1:0] clk_cnt;
        logic [TRK_W-1:0] lrc_acc;
        logic [7:0] gap_cnt;
        logic lost_pend;
        logic blk_open;
        logic [1:0] chk_cnt;
        logic [TRK_W-1:0] wr_char;
        logic [TRK_W-1:0] crc;
        logic raw_busy;
        logic [CNT_W-1:0] raw_cnt;
        logic [TRK_W-1:0] rb_acc;
        logic gseq;
        logic [7:0] gseq_cnt;
        logic ld_over;
        logic [9:0] ld_cnt;
        tdc_wr_out_s wo;
        tdc_rd_out_s ro;
    } tdc_state_s;
endpackage : tdc_pkg

/* hdl/tdc_sync.sv */
// Two-stage synchroniser for all asynchronous pin inputs
`timescale 1ns/10ps
module tdc_sync
    import tdc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Pins in, synchronised pins out
    input wire tdc_pins_s pins,
    output tdc_pins_s pins_q
);
    tdc_sync_s st;
    tdc_sync_s next_st;

    always_comb begin
        next_st.meta = pins;
        next_st.q = st.meta;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pins_q = st.q;
endmodule : tdc_sync

/* hdl/tdc_top.sv */
// Tape character write/read data path with parity, check characters and timing checks
// Summary of operation
// R01: Binary mode uses odd lateral parity always
// R02: Nine-track bytes always carry odd parity
// R03: Block end returns all tracks to reference
// R04: Odd transition count per track flags error
// R05: Check character four spaces after last data
// R06: Nine-track writes append a CRC character
// R07: Character late past 17 ticks flags lost
// R08: Head polarity flips per one bit only
// R09: Read-back mismatch raises write-check error
// R10: Write-check verdict within 1.9 ms of writing
// R11: No ring: no write mode, no erase
// R12: No-ring write attempt lights protect lamp, status
// R13: Read units stop at load point marker
// R14: First flux on any track starts skew delay
// R15: Delay end loads register, clock follows later
// R16: External system strobes data on read clock
// R17: No character for three intervals: gap detect
// R18: Check character shown but clock suppressed
// R19: Error flags hold until next block starts; the write-check error (raw_err) clears at each written character instead
`timescale 1ns/10ps
module tdc_top
    import tdc_pkg::*;
#(
    parameter int TICK_CYC_P = TICK_CYC,
    parameter int SKEW_CYC_P = SKEW_CYC,
    parameter int RAW_CYC_P = RAW_CYC,
    parameter logic [8:0] CRC_POLY = CRC_POLY_DEF,
    parameter bit READ_EQUIPPED = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Asynchronous pins from the data system and transport
    input wire tdc_pins_s pins,
    // Write side and transport outputs
    output tdc_wr_out_s wr_out,
    // Read side outputs
    output tdc_rd_out_s rd_out
);
    tdc_state_s st;
    tdc_state_s next_st;
    tdc_pins_s sp;

    logic step_e;
    logic gap_e;
    logic load_e;
    logic rdcmd_e;
    logic [TRK_W-1:0] rd_e;
    logic [TRK_W-1:0] rb_e;
    logic odd_req;
    logic [TRK_W-1:0] wch;
    logic space;
    logic wr_go;
    logic emit;
    logic [TRK_W-1:0] ec;
    logic lrc_emit;
    logic crc_emit;
    logic [7:0] lrc_at;
    logic [TRK_W-1:0] accn;
    logic [TRK_W-1:0] lrc_new;
    logic par_bad;
    logic chk_char;
    logic new_blk;
    logic [1:0] chk_last;

    tdc_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .pins(pins),
        .pins_q(sp)
    );

    function automatic logic [8:0] tdc_crc_step(input logic [8:0] c, input logic [8:0] d);
        logic [8:0] r;
        r = {c[7:0], 1'b0} ^ d;
        if (c[8]) begin
            r = r ^ CRC_POLY;
        end
        return r;
    endfunction : tdc_crc_step

    always_comb begin
        next_st = st;
        next_st.pv = sp;
        step_e = sp.wr_step & ~st.pv.wr_step;
        gap_e = sp.wr_gap & ~st.pv.wr_gap;
        load_e = sp.load_cmd & ~st.pv.load_cmd;
        rdcmd_e = sp.rd_cmd & ~st.pv.rd_cmd;
        rd_e = sp.rd_flux & ~st.pv.rd_flux;
        rb_e = sp.rb_flux & ~st.pv.rb_flux;
        next_st.wo.head_pulse = 1'b0;
        next_st.wo.tape_step = 1'b0;
        next_st.ro.rd_clk = 1'b0;
        next_st.tick = 1'b0;

        // Character-clock tick divider and character-space marker
        if (st.sub_div == CNT_W'(TICK_CYC_P - 1)) begin
            next_st.sub_div = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.sub_div = st.sub_div + 1'b1;
        end
        space = st.tick && (st.sp_cnt == SPACE_LAST);
        if (st.tick) begin
            next_st.sp_cnt = space ? 4'h0 : st.sp_cnt + 4'h1;
        end

        // Write mode needs the ring; erase follows write mode
        next_st.wo.write_mode = sp.wr_sel & sp.ring_in; // see R11
        next_st.wo.erase_en = sp.wr_sel & sp.ring_in; // see R11
        if (!sp.ring_in && (sp.wr_sel || step_e || gap_e)) begin
            next_st.wo.protect_lamp = 1'b1; // see R12
            next_st.wo.protect_status = 1'b1; // see R12
        end else if (sp.ring_in) begin
            next_st.wo.protect_lamp = 1'b0;
            next_st.wo.protect_status = 1'b0;
        end

        // Lateral parity: odd for binary and nine-track, even for seven-track BCD
        odd_req = sp.nine_track | sp.binary_mode;
        if (sp.nine_track) begin
            wch = {~^sp.wr_data, sp.wr_data}; // see R02
        end else begin
            wch = {2'b00, (odd_req ? ~^sp.wr_data[5:0] : ^sp.wr_data[5:0]),
                   sp.wr_data[5:0]}; // see R01
        end

        // Write-check window; steps inside it are ignored
        if (st.raw_busy) begin
            next_st.rb_acc = st.rb_acc | rb_e;
            next_st.raw_cnt = st.raw_cnt + 1'b1;
            if (st.raw_cnt == CNT_W'(RAW_CYC_P - 1)) begin
                next_st.raw_busy = 1'b0;
                next_st.wo.raw_err = ((st.rb_acc | rb_e) != st.wr_char); // see R09, R10
            end
        end

        // Gap sequence: CRC then LRC, or LRC alone, at fixed spacing
        lrc_at = sp.nine_track ? 8'(CHECK_SPACES + CHECK_SPACES) : CHECK_SPACES;
        crc_emit = 1'b0;
        lrc_emit = 1'b0;
        if (st.gseq && space) begin
            next_st.gseq_cnt = st.gseq_cnt + 8'h01;
            next_st.wo.tape_step = 1'b1;
            if (sp.nine_track && (next_st.gseq_cnt == CHECK_SPACES)) begin
                crc_emit = st.wo.write_mode; // see R06
            end
            if (next_st.gseq_cnt == lrc_at) begin
                lrc_emit = st.wo.write_mode; // see R05
                next_st.gseq = 1'b0;
                next_st.wo.gap_busy = 1'b0;
                next_st.crc = '0;
            end
        end

        wr_go = st.wo.write_mode && !st.raw_busy && !st.gseq;
        emit = 1'b0;
        ec = '0;
        if (step_e && wr_go) begin
            emit = 1'b1;
            ec = wch;
            if (sp.nine_track) begin
                next_st.crc = tdc_crc_step(st.crc, wch); // see R06
            end
        end else if (gap_e && wr_go) begin
            next_st.gseq = 1'b1;
            next_st.gseq_cnt = '0;
            next_st.wo.gap_busy = 1'b1;
        end else if (crc_emit) begin
            emit = 1'b1;
            ec = st.crc;
        end else if (lrc_emit) begin
            emit = 1'b1;
            ec = st.wo.head_pol; // see R03, R04
        end
        if (emit) begin
            // Polarity flip-flops toggle only where a one is written
            next_st.wo.head_pol = st.wo.head_pol ^ ec; // see R08
            next_st.wo.head_pulse = 1'b1;
            next_st.wo.tape_step = 1'b1;
            next_st.wr_char = ec;
            next_st.raw_busy = 1'b1;
            next_st.raw_cnt = '0;
            next_st.rb_acc = '0;
            next_st.wo.raw_err = 1'b0;
        end

        // Loading: read units stop on the marker, write-only units advance on
        if (load_e && !st.wo.load_busy) begin
            next_st.wo.load_busy = 1'b1;
            next_st.ld_over = 1'b0;
            next_st.ld_cnt = '0;
        end else if (st.wo.load_busy && !st.ld_over && sp.load_point) begin
            next_st.wo.load_busy = !READ_EQUIPPED; // see R13
            next_st.ld_over = !READ_EQUIPPED;
        end else if (st.wo.load_busy && space) begin
            next_st.wo.tape_step = 1'b1;
            if (st.ld_over) begin
                next_st.ld_cnt = st.ld_cnt + 10'h001;
                if (st.ld_cnt == BOT_STEPS_M1) begin
                    next_st.wo.load_busy = 1'b0;
                end
            end
        end

        // Gap and lost-character timing in character-clock ticks
        if (rdcmd_e) begin
            next_st.gap_cnt = '0;
        end else if (sp.rd_cmd && st.tick && st.gap_cnt != TICK_SAT) begin
            next_st.gap_cnt = st.gap_cnt + 8'h01;
        end
        if (next_st.gap_cnt >= GAP_TICKS) begin
            next_st.ro.gap_detect = 1'b1; // see R17
        end
        if (st.blk_open && next_st.gap_cnt >= LOST_TICKS) begin
            next_st.lost_pend = 1'b1; // see R07
        end

        // Skew delay from first flux on any track, then load register
        accn = st.acc | rd_e;
        lrc_new = st.lrc_acc ^ accn;
        par_bad = sp.nine_track ? ~^accn : ((^accn[PAR7_BIT:0]) != odd_req);
        chk_last = sp.nine_track ? 2'b01 : 2'b00;
        chk_char = 1'b0;
        new_blk = 1'b0;
        if (!st.rd_busy) begin
            if (|rd_e) begin
                next_st.rd_busy = 1'b1; // see R14
                next_st.skew_cnt = '0;
                next_st.acc = rd_e;
            end
        end else begin
            next_st.acc = accn;
            next_st.skew_cnt = st.skew_cnt + 1'b1;
            if (st.skew_cnt == CNT_W'(SKEW_CYC_P - 1)) begin
                next_st.rd_busy = 1'b0;
                next_st.ro.data = accn; // see R15
                next_st.gap_cnt = '0;
                next_st.ro.gap_detect = 1'b0;
                next_st.lost_pend = 1'b0;
                next_st.lrc_acc = lrc_new;
                if (st.ro.gap_detect && st.blk_open) begin
                    chk_char = 1'b1; // see R18
                    next_st.chk_cnt = st.chk_cnt + 2'b01;
                    if (st.chk_cnt == chk_last) begin
                        next_st.blk_open = 1'b0;
                        next_st.ro.lrc_err = st.ro.lrc_err | (|lrc_new); // see R04
                    end
                end else if (!st.blk_open) begin
                    new_blk = 1'b1;
                    next_st.blk_open = 1'b1;
                    next_st.chk_cnt = '0;
                    next_st.lrc_acc = accn;
                    next_st.ro.par_err = par_bad; // see R19
                    next_st.ro.lrc_err = 1'b0;
                    next_st.ro.lost_err = 1'b0;
                end else begin
                    next_st.ro.par_err = st.ro.par_err | par_bad; // see R01, R02
                    next_st.ro.lost_err = st.ro.lost_err | st.lost_pend; // see R07
                end
                if (!chk_char) begin
                    next_st.clk_wait = 1'b1;
                    next_st.clk_cnt = '0;
                end
            end
        end

        // Read clock a short time after the register settles
        if (st.clk_wait) begin
            next_st.clk_cnt = st.clk_cnt + 1'b1;
            if (st.clk_cnt == CNT_W'(RDCLK_DELAY_CYC - 1)) begin
                next_st.clk_wait = 1'b0;
                next_st.ro.rd_clk = 1'b1; // see R15, R16
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wr_out = st.wo;
    assign rd_out = st.ro;

    property p_pulse_needs_mode;
        @(posedge mclk) disable iff (rst) st.wo.head_pulse |-> $past(st.wo.write_mode);
    endproperty
    a_pulse_needs_mode: assert property (p_pulse_needs_mode) // see R11
        else $error("write pulse without write mode");

    property p_erase_needs_ring;
        @(posedge mclk) disable iff (rst) st.wo.erase_en |-> $past(sp.ring_in);
    endproperty
    a_erase_needs_ring: assert property (p_erase_needs_ring) // see R11
        else $error("erase enabled without protect ring");

    property p_protect_lamp;
        @(posedge mclk) disable iff (rst)
            (!sp.ring_in && sp.wr_sel) |=> (st.wo.protect_lamp && st.wo.protect_status);
    endproperty
    a_protect_lamp: assert property (p_protect_lamp) // see R12
        else $error("protect indication missing");

    property p_nine_odd;
        @(posedge mclk) disable iff (rst)
            ($past(step_e && wr_go) && $past(sp.nine_track) && st.wo.head_pulse) |-> (^st.wr_char);
    endproperty
    a_nine_odd: assert property (p_nine_odd) // see R02
        else $error("nine-track byte written with even parity");

    property p_binary_odd;
        @(posedge mclk) disable iff (rst)
            ($past(step_e && wr_go) && $past(sp.binary_mode) && !$past(sp.nine_track)
             && st.wo.head_pulse) |-> (^st.wr_char[PAR7_BIT:0]);
    endproperty
    a_binary_odd: assert property (p_binary_odd) // see R01
        else $error("binary character written with even parity");

    property p_reference;
        @(posedge mclk) disable iff (rst) lrc_emit |=> (st.wo.head_pol == '0) && st.wo.head_pulse;
    endproperty
    a_reference: assert property (p_reference) // see R03
        else $error("tracks not at reference after check character");

    property p_lrc_spacing;
        @(posedge mclk) disable iff (rst) lrc_emit |-> (st.gseq_cnt + 8'h01 == lrc_at);
    endproperty
    a_lrc_spacing: assert property (p_lrc_spacing) // see R05
        else $error("check character misplaced");

    property p_raw_bound;
        @(posedge mclk) disable iff (rst) st.raw_busy |-> (st.raw_cnt < CNT_W'(RAW_CYC_P));
    endproperty
    a_raw_bound: assert property (p_raw_bound) // see R10
        else $error("write-check verdict late");

    property p_lost_time;
        @(posedge mclk) disable iff (rst) $rose(st.lost_pend) |-> (st.gap_cnt >= LOST_TICKS);
    endproperty
    a_lost_time: assert property (p_lost_time) // see R07
        else $error("lost character flagged early");

    property p_gap_time;
        @(posedge mclk) disable iff (rst) $rose(st.ro.gap_detect) |-> (st.gap_cnt >= GAP_TICKS);
    endproperty
    a_gap_time: assert property (p_gap_time) // see R17
        else $error("gap detect raised early");

    property p_data_on_skew;
        @(posedge mclk) disable iff (rst) $changed(st.ro.data) |-> $past(st.rd_busy);
    endproperty
    a_data_on_skew: assert property (p_data_on_skew) // see R14
        else $error("output register changed outside skew delay");

    property p_clk_after_data;
        @(posedge mclk) disable iff (rst) st.ro.rd_clk |-> $stable(st.ro.data) && !st.rd_busy;
    endproperty
    a_clk_after_data: assert property (p_clk_after_data) // see R15
        else $error("read clock while data moving");

    property p_check_no_clock;
        @(posedge mclk) disable iff (rst) chk_char |=> !st.clk_wait;
    endproperty
    a_check_no_clock: assert property (p_check_no_clock) // see R18
        else $error("read clock armed for check character");

    property p_sticky;
        @(posedge mclk) disable iff (rst) $fell(st.ro.par_err) |-> $past(new_blk);
    endproperty
    a_sticky: assert property (p_sticky) // see R19
        else $error("parity error cleared inside a block");
endmodule : tdc_top

/* verification/tdc_far_model.sv */
// Far-side model: strobes read characters and echoes written flux back
`timescale 1ns/10ps
module tdc_far_model
    import tdc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Device outputs
    input wire tdc_wr_out_s wr_out,
    input wire tdc_rd_out_s rd_out,
    // Read-back fault mask and flux
    input wire logic [TRK_W-1:0] flip_mask,
    output logic [TRK_W-1:0] rb_flux,
    // Captured characters
    output logic [TRK_W-1:0] cap_data,
    output logic [7:0] cap_count
);
    logic [TRK_W-1:0] last_pol;
    logic [2:0] hold;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rb_flux <= '0;
            cap_data <= '0;
            cap_count <= 8'h00;
            last_pol <= '0;
            hold <= 3'h0;
        end else begin
            if (rd_out.rd_clk) begin
                cap_data <= rd_out.data;
                cap_count <= cap_count + 8'h01;
            end
            // A flipped track stands for a flaw on the tape
            if (wr_out.head_pulse) begin
                rb_flux <= (wr_out.head_pol ^ last_pol) ^ flip_mask;
                last_pol <= wr_out.head_pol;
                hold <= 3'h4;
            end else if (hold != 3'h0) begin
                hold <= hold - 3'h1;
            end else begin
                rb_flux <= '0;
            end
        end
    end
endmodule : tdc_far_model

/* verification/tape_data_check_path_test.sv */
// Self-checking bench for the tape character data path
`timescale 1ns/10ps
module tape_data_check_path_test
    import tdc_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    tdc_pins_s drv;
    tdc_pins_s pins;
    tdc_wr_out_s wr_out;
    tdc_rd_out_s rd_out;
    logic [TRK_W-1:0] rb_flux;
    logic [TRK_W-1:0] flip_mask;
    logic [TRK_W-1:0] cap_data;
    logic [7:0] cap_count;
    logic [8:0] pol;
    int bad_count = 0;
    int compares = 0;

    always #10 mclk = ~mclk;

    always_comb begin
        pins = drv;
        pins.rb_flux = rb_flux;
    end

    // Short counts keep the run small
    tdc_top #(.TICK_CYC_P(20), .SKEW_CYC_P(90), .RAW_CYC_P(50)) dut_u (
        .mclk(mclk), .rst(rst), .pins(pins), .wr_out(wr_out), .rd_out(rd_out));

    tdc_far_model far_u (
        .mclk(mclk), .rst(rst), .wr_out(wr_out), .rd_out(rd_out), .flip_mask(flip_mask),
        .rb_flux(rb_flux), .cap_data(cap_data), .cap_count(cap_count));

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    // Sample away from the edge so design updates have landed
    task automatic look(input int n);
        cyc(n);
        @(negedge mclk);
    endtask : look

    task automatic wr_char(input logic nine, input logic [7:0] d, input logic [8:0] flip);
        int n;
        logic [8:0] c;
        c = nine ? {~^d, d} : {2'b00, ~^d[5:0], d[5:0]};
        pol = pol ^ c;
        n = 0;
        @(posedge mclk);
        drv.nine_track <= nine;
        drv.wr_data <= d;
        flip_mask <= flip;
        cyc(4);
        drv.wr_step <= 1'b1;
        while (wr_out.head_pulse !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        chk(9'(n), 9'h004, "step to pulse");
        chk(wr_out.head_pol, pol, "head polarity");
        @(posedge mclk);
        drv.wr_step <= 1'b0;
        // Next step no sooner than the check window allows
        look(55);
        chk(wr_out.raw_err, 9'(flip != 9'h000), "write check");
    endtask : wr_char

    task automatic t_protect();
        @(posedge mclk);
        drv.ring_in <= 1'b0;
        drv.wr_sel <= 1'b1;
        cyc(10);
        drv.wr_step <= 1'b1;
        look(20);
        chk(wr_out.write_mode, 9'h000, "write mode");
        chk(wr_out.erase_en, 9'h000, "erase");
        chk(wr_out.head_pol, 9'h000, "no write");
        chk({wr_out.protect_lamp, wr_out.protect_status}, 9'h003, "protect");
        @(posedge mclk);
        drv.wr_step <= 1'b0;
        drv.ring_in <= 1'b1;
        look(10);
        chk(wr_out.write_mode, 9'h001, "write mode on");
    endtask : t_protect

    task automatic t_gap();
        int n;
        int first;
        int pulses;
        int last;
        int steps;
        int sp_cyc;
        n = 0;
        first = 0;
        pulses = 0;
        last = 0;
        steps = 0;
        // One character space is ten ticks of the bench's 20-cycle tick
        sp_cyc = TICKS_PER_CHAR * 20;
        @(posedge mclk);
        drv.wr_gap <= 1'b1;
        look(4);
        chk(wr_out.gap_busy, 9'h001, "gap busy");
        while (wr_out.gap_busy === 1'b1 && n < 3000) begin
            @(negedge mclk);
            n++;
            if (wr_out.tape_step === 1'b1) begin
                steps++;
            end
            if (wr_out.head_pulse === 1'b1) begin
                pulses++;
                last = n;
                if (first == 0) first = n;
            end
        end
        chk(9'(pulses), 9'h002, "check chars");
        chk(9'(first >= (CHECK_SPACES - 1) * sp_cyc && first <= CHECK_SPACES * sp_cyc), 9'h001,
            "check spacing");
        chk(9'(last - first == CHECK_SPACES * sp_cyc), 9'h001, "crc to lrc");
        chk(9'(steps), 9'(CHECK_SPACES * 2), "gap steps");
        chk(wr_out.head_pol, 9'h000, "reference");
        pol = '0;
        @(posedge mclk);
        drv.wr_gap <= 1'b0;
    endtask : t_gap

    task automatic t_load();
        @(posedge mclk);
        drv.wr_sel <= 1'b0;
        drv.load_cmd <= 1'b1;
        look(30);
        chk(wr_out.load_busy, 9'h001, "loading");
        @(posedge mclk);
        drv.load_point <= 1'b1;
        look(6);
        chk(wr_out.load_busy, 9'h000, "stop at marker");
        @(posedge mclk);
        drv.load_cmd <= 1'b0;
    endtask : t_load

    task automatic rd_char(input logic [8:0] c, input logic want_clk);
        int n;
        logic [7:0] cnt0;
        cnt0 = cap_count;
        n = 4;
        @(posedge mclk);
        drv.rd_flux <= c;
        cyc(4);
        drv.rd_flux <= '0;
        while (rd_out.rd_clk !== 1'b1 && n < 260) begin
            @(negedge mclk);
            n++;
        end
        if (want_clk) begin
            chk(9'(n >= 186 && n <= 200), 9'h001, "read clock delay");
            @(negedge mclk);
            chk(cap_data, c, "captured");
        end else begin
            chk(9'(cap_count - cnt0), 9'h000, "clock suppressed");
        end
        chk(rd_out.data, c, "output register");
    endtask : rd_char

    task automatic t_read();
        @(posedge mclk);
        drv.nine_track <= 1'b0;
        drv.binary_mode <= 1'b1;
        drv.rd_cmd <= 1'b1;
        cyc(5);
        rd_char(9'h043, 1'b1);
        rd_char(9'h045, 1'b1);
        look(560);
        chk(rd_out.gap_detect, 9'h001, "gap detect");
        rd_char(9'h006, 1'b0);
        chk({rd_out.par_err, rd_out.lrc_err, rd_out.lost_err}, 9'h000, "clean");
        look(700);
        rd_char(9'h043, 1'b1);
        look(200);
        rd_char(9'h045, 1'b1);
        look(560);
        rd_char(9'h002, 1'b0);
        chk({rd_out.par_err, rd_out.lrc_err, rd_out.lost_err}, 9'h003, "lrc lost");
        look(700);
        chk({rd_out.par_err, rd_out.lrc_err, rd_out.lost_err}, 9'h003, "held");
        rd_char(9'h003, 1'b1);
        chk({rd_out.par_err, rd_out.lrc_err, rd_out.lost_err}, 9'h004, "parity");
    endtask : t_read

    initial begin
        drv = '0;
        drv.ring_in = 1'b1;
        drv.binary_mode = 1'b1;
        flip_mask = '0;
        pol = '0;
        cyc(3);
        rst <= 1'b0;
        cyc(5);
        t_protect();
        wr_char(1'b0, 8'h05, 9'h000);
        wr_char(1'b1, 8'h03, 9'h001);
        t_gap();
        t_load();
        t_read();
        wrap_up();
    end

    initial begin
        cyc(40000);
        bad_count++;
        $display("wrong value at %0t: run hung", $time);
        wrap_up();
    end
endmodule : tape_data_check_path_test
